// file: src/mft_pkg.sv
// Package with register map, field layout and encodings of the timer.
package mft_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// Register byte offsets on the plain register port.
	localparam logic [7:0] OFS_CNT1 = 8'h40;
	localparam logic [7:0] OFS_RCA = 8'h42;
	localparam logic [7:0] OFS_RCB = 8'h44;
	localparam logic [7:0] OFS_CNT2 = 8'h46;
	localparam logic [7:0] OFS_PRSC = 8'h48;
	localparam logic [7:0] OFS_CKC = 8'h4A;
	localparam logic [7:0] OFS_CTRL = 8'h4C;
	localparam logic [7:0] OFS_ICTL = 8'h4E;
	localparam logic [7:0] OFS_ICLR = 8'h50;
	// Clock select codes, one per counter field.
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_PRE = 3'h1;
	localparam logic [2:0] CS_EXT = 3'h2;
	localparam logic [2:0] CS_ACC = 3'h3;
	localparam logic [2:0] CS_SLOW = 3'h4;
	// Field positions.
	localparam int PS_W = 5;
	localparam int C1_LSB = 0;
	localparam int C2_LSB = 3;
	localparam int IEN_LSB = 4;
	localparam int SRC_A = 0;
	localparam int SRC_B = 1;
	localparam int SRC_C = 2;
	localparam int SRC_D = 3;
	// Operating modes 1 to 4.
	localparam logic [1:0] MD_PWM = 2'h0;
	localparam logic [1:0] MD_DCAP = 2'h1;
	localparam logic [1:0] MD_DUAL = 2'h2;
	localparam logic [1:0] MD_SCAP = 2'h3;
	// Reset and fixed values.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] ICLR_READ = 8'hFF;
	localparam logic [15:0] PRESET_VAL = 16'hFFFF;
	localparam int SYNC_N = 3;

	// Mode and pin control register, bit 7 down to bit 0.
	typedef struct packed {
		logic global_timer_enable;
		logic pin_a_output_state;
		logic pin_b_function_enable;
		logic pin_a_function_enable;
		logic pin_b_edge_polarity;
		logic pin_a_edge_polarity;
		logic [1:0] mode;
	} mft_ctrl_t;

	// Register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mft_req_t;
endpackage

// file: src/mft_timer.sv
// Dual 16-bit multi-function timer with control and status registers.
//
// Functional notes
// R1 - Prescaled tick divides system clock by prescale value plus one.
// R2 - Clock select codes 1 to 4 start a counter; reset clears both selects.
// R3 - First select: stop, prescaled, event on B, accumulate on B, slow.
// R4 - Second select uses the same encoding as the first.
// R5 - Software uses event, accumulate and stop codes only in allowed modes.
// R6 - Counters and reload registers are read/write and not reset.
// R7 - Mode field: PWM, dual capture, dual counter, single capture.
// R8 - Edge polarity bit: 0 falling, 1 rising.
// R9 - Accumulate counts only while pin B equals its polarity bit.
// R10 - Pin A enable: preset counter 1 in mode 2, else PWM output.
// R11 - Pin B enable presets counter 1 in mode 2, counter 2 in mode 4.
// R12 - Output state bit follows PWM; software write beats hardware update.
// R13 - Global enable low stops clocks and blocks counter and pending writes.
// R14 - Global enable low clears prescaler and pending, pin A becomes input.
// R15 - Interrupt control: enables in bits 7..4, pending in 3..0, reset zero.
// R16 - Pending set by hardware or by writing one; writing zero ignored.
// R17 - Request raised only when the source enable is one.
// R18 - Writing one to a clear bit clears that pending flag.
// R19 - Clear register always reads all ones.
// R20 - Software never read-modify-writes the clear register.
// R21 - Sources A, B, C form request 1; source D forms request 2.
// R22 - D on counter 2 underflow or reload; A on reload or pin A capture.
// R23 - PWM pin A toggles on each counter 1 underflow outside mode 2.
// R24 - Reserved clock codes leave the counter stopped.
// R25 - Pins and slow clock are synchronised; each edge is one pulse.
// R26 - Reserved prescaler and clock select bits read zero.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module mft_timer (
	input wire logic mclk, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [7:0] reg_addr, // Register byte address.
	input wire logic [15:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
	input wire logic timer_io_pin_a_in, // Pin A level.
	output logic timer_io_pin_a_out, // Pin A drive level.
	output logic timer_io_pin_a_oe, // Pin A output enable.
	input wire logic timer_io_pin_b_in, // Pin B level.
	input wire logic slow_clk_in, // Slow clock source.
	output logic timer_irq1, // Request for sources A, B, C.
	output logic timer_irq2 // Request for source D.
);

	mft_pkg::mft_req_t req;
	mft_pkg::mft_ctrl_t ctl_r;
	logic [mft_pkg::PS_W-1:0] prescale_value_r;
	logic [2:0] first_clock_select_r;
	logic [2:0] second_clock_select_r;
	logic [15:0] first_counter_value_r;
	logic [15:0] second_counter_value_r;
	logic [15:0] reload_capture_first_r;
	logic [15:0] reload_capture_second_r;
	logic [3:0] irq_en_r;
	logic [3:0] pending_r;
	logic [3:0] pending_nxt;
	logic [mft_pkg::PS_W-1:0] pre_cnt_r;
	logic pre_tick;
	logic [2:0] sync_r [0:mft_pkg::SYNC_N-1];
	logic [2:0] lvl_r;
	logic [2:0] chg;
	logic ta_evt, tb_evt, slow_evt;
	logic tick1, tick2, uf1, uf2;
	logic acc_ok;
	logic wr_ctrl, wr_ckc, wr_prsc, wr_ictl, wr_iclr;
	logic wr_cnt1, wr_cnt2, wr_rca, wr_rcb;
	logic md2, md4, pwm_on;
	logic [3:0] hw_set;

	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

	////////////////////////////////////////////////////////////////////////
	// Address decode. Counter and reload writes need the global enable.

	always_comb begin
		wr_prsc = 1'b0;
		wr_ckc = 1'b0;
		wr_ctrl = 1'b0;
		wr_ictl = 1'b0;
		wr_iclr = 1'b0;
		wr_cnt1 = 1'b0;
		wr_cnt2 = 1'b0;
		wr_rca = 1'b0;
		wr_rcb = 1'b0;
		if (!req.wr) begin
			wr_prsc = 1'b0;
		end else if (req.addr == mft_pkg::OFS_PRSC) begin
			wr_prsc = 1'b1;
		end else if (req.addr == mft_pkg::OFS_CKC) begin
			wr_ckc = 1'b1;
		end else if (req.addr == mft_pkg::OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (req.addr == mft_pkg::OFS_ICTL) begin
			wr_ictl = 1'b1;
		end else if (req.addr == mft_pkg::OFS_ICLR) begin
			wr_iclr = 1'b1;
		end else if (req.addr == mft_pkg::OFS_CNT1) begin
			wr_cnt1 = ctl_r.global_timer_enable; // R13
		end else if (req.addr == mft_pkg::OFS_CNT2) begin
			wr_cnt2 = ctl_r.global_timer_enable; // R13
		end else if (req.addr == mft_pkg::OFS_RCA) begin
			wr_rca = ctl_r.global_timer_enable; // R13
		end else if (req.addr == mft_pkg::OFS_RCB) begin
			wr_rcb = ctl_r.global_timer_enable; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge mclk) begin
		if (rst) begin
			prescale_value_r <= '0;
		end else if (wr_prsc) begin
			prescale_value_r <= req.wdata[mft_pkg::PS_W-1:0]; // R26
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			first_clock_select_r <= mft_pkg::CS_STOP; // R2
			second_clock_select_r <= mft_pkg::CS_STOP; // R2
		end else if (wr_ckc) begin
			first_clock_select_r <= req.wdata[mft_pkg::C1_LSB +: 3]; // R3
			second_clock_select_r <= req.wdata[mft_pkg::C2_LSB +: 3]; // R4
		end
	end

	assign md2 = (ctl_r.mode == mft_pkg::MD_DCAP); // R7
	assign md4 = (ctl_r.mode == mft_pkg::MD_SCAP); // R7
	assign pwm_on = ctl_r.global_timer_enable && ctl_r.pin_a_function_enable && !md2; // R10 R14

	// A software write takes priority over the toggle so it wins a collision.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_r <= mft_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctl_r <= req.wdata[7:0]; // R12
		end else if (pwm_on && uf1) begin
			ctl_r.pin_a_output_state <= !ctl_r.pin_a_output_state; // R23
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers. A change counts once stages two and three agree.

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < mft_pkg::SYNC_N; i++) begin
				sync_r[i] <= '0;
			end
			lvl_r <= '0;
		end else begin
			sync_r[0] <= {slow_clk_in, timer_io_pin_b_in, timer_io_pin_a_in};
			for (int i = 1; i < mft_pkg::SYNC_N; i++) begin
				sync_r[i] <= sync_r[i-1];
			end
			for (int i = 0; i < 3; i++) begin
				if (chg[i]) begin
					lvl_r[i] <= sync_r[2][i];
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			chg[i] = (sync_r[1][i] == sync_r[2][i]) && (sync_r[2][i] != lvl_r[i]);
		end
	end

	assign ta_evt = ctl_r.global_timer_enable && chg[0] && (sync_r[2][0] == ctl_r.pin_a_edge_polarity); // R8 R25
	assign tb_evt = ctl_r.global_timer_enable && chg[1] && (sync_r[2][1] == ctl_r.pin_b_edge_polarity); // R8 R25
	assign slow_evt = ctl_r.global_timer_enable && chg[2] && sync_r[2][2]; // R25

	////////////////////////////////////////////////////////////////////////
	// Prescaler and counter clock selection.

	always_ff @(posedge mclk) begin
		if (rst || !ctl_r.global_timer_enable) begin
			pre_cnt_r <= '0; // R14
		end else if (pre_cnt_r >= prescale_value_r) begin
			pre_cnt_r <= '0; // R1
		end else begin
			pre_cnt_r <= pre_cnt_r + 1'b1;
		end
	end

	assign pre_tick = ctl_r.global_timer_enable && (pre_cnt_r >= prescale_value_r); // R1

	// Every source is an argument: a continuous assignment only wakes up
	// on its operands, so reads of module signals inside would go stale.
	function automatic logic sel_tick(input logic [2:0] sel, input logic pre,
		input logic ext, input logic acc_ok, input logic slow);
		logic t;
		t = 1'b0;
		case (sel)
			mft_pkg::CS_PRE: t = pre; // R1
			mft_pkg::CS_EXT: t = ext;
			mft_pkg::CS_ACC: t = pre && acc_ok; // R9
			mft_pkg::CS_SLOW: t = slow;
			default: t = 1'b0; // R24
		endcase
		return t;
	endfunction

	assign acc_ok = (lvl_r[1] == ctl_r.pin_b_edge_polarity); // R9
	assign tick1 = ctl_r.global_timer_enable // R2 R13
		&& sel_tick(first_clock_select_r, pre_tick, tb_evt, acc_ok, slow_evt);
	assign tick2 = ctl_r.global_timer_enable // R2 R13
		&& sel_tick(second_clock_select_r, pre_tick, tb_evt, acc_ok, slow_evt);
	assign uf1 = tick1 && (first_counter_value_r == '0);
	assign uf2 = tick2 && (second_counter_value_r == '0);

	////////////////////////////////////////////////////////////////////////
	// Counters and reload/capture registers; none of them is reset.

	always_ff @(posedge mclk) begin
		if (wr_cnt1) begin
			first_counter_value_r <= req.wdata; // R6
		end else if (md2 && ((ta_evt && ctl_r.pin_a_function_enable) || (tb_evt && ctl_r.pin_b_function_enable))) begin
			first_counter_value_r <= mft_pkg::PRESET_VAL; // R10 R11
		end else if (uf1) begin
			first_counter_value_r <= md2 ? mft_pkg::PRESET_VAL : reload_capture_first_r;
		end else if (tick1) begin
			first_counter_value_r <= first_counter_value_r - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_cnt2) begin
			second_counter_value_r <= req.wdata; // R6
		end else if (md4 && tb_evt && ctl_r.pin_b_function_enable) begin
			second_counter_value_r <= mft_pkg::PRESET_VAL; // R11
		end else if (uf2) begin
			second_counter_value_r <= (md2 || md4) ? mft_pkg::PRESET_VAL
				: reload_capture_second_r;
		end else if (tick2) begin
			second_counter_value_r <= second_counter_value_r - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_rca) begin
			reload_capture_first_r <= req.wdata; // R6
		end else if (md2 && ta_evt) begin
			reload_capture_first_r <= first_counter_value_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (wr_rcb) begin
			reload_capture_second_r <= req.wdata; // R6
		end else if (md2 && tb_evt) begin
			reload_capture_second_r <= first_counter_value_r;
		end else if (md4 && tb_evt) begin
			reload_capture_second_r <= second_counter_value_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt enables and pending flags. A set beats a clear.

	always_comb begin
		hw_set = '0;
		hw_set[mft_pkg::SRC_A] = md2 ? ta_evt : uf1; // R22
		hw_set[mft_pkg::SRC_B] = (md2 || md4) && tb_evt;
		hw_set[mft_pkg::SRC_C] = md2 && uf1;
		hw_set[mft_pkg::SRC_D] = uf2; // R22
		pending_nxt = pending_r;
		if (wr_iclr) begin
			pending_nxt = pending_nxt & ~req.wdata[3:0]; // R18
		end
		if (wr_ictl && ctl_r.global_timer_enable) begin
			pending_nxt = pending_nxt | req.wdata[3:0]; // R16
		end
		pending_nxt = pending_nxt | hw_set; // R16
		if (!ctl_r.global_timer_enable) begin
			pending_nxt = '0; // R14
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pending_r <= '0; // R15
			irq_en_r <= '0; // R15
		end else begin
			pending_r <= pending_nxt;
			if (wr_ictl) begin
				irq_en_r <= req.wdata[mft_pkg::IEN_LSB +: 4]; // R15
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_irq1 <= 1'b0;
			timer_irq2 <= 1'b0;
		end else begin
			timer_irq1 <= |(pending_r[2:0] & irq_en_r[2:0]); // R17 R21
			timer_irq2 <= pending_r[3] && irq_en_r[3]; // R17 R21
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin A drive and read port.

	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_io_pin_a_oe <= 1'b0;
		end else begin
			timer_io_pin_a_oe <= pwm_on; // R10 R14
		end
	end

	assign timer_io_pin_a_out = ctl_r.pin_a_output_state; // R12

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (!req.rd) begin
			reg_rdata <= '0;
		end else if (req.addr == mft_pkg::OFS_PRSC) begin
			reg_rdata <= {11'h000, prescale_value_r}; // R26
		end else if (req.addr == mft_pkg::OFS_CKC) begin
			reg_rdata <= {10'h000, second_clock_select_r, first_clock_select_r};
		end else if (req.addr == mft_pkg::OFS_CTRL) begin
			reg_rdata <= {8'h00, ctl_r};
		end else if (req.addr == mft_pkg::OFS_ICTL) begin
			reg_rdata <= {8'h00, irq_en_r, pending_r}; // R15
		end else if (req.addr == mft_pkg::OFS_ICLR) begin
			reg_rdata <= {8'h00, mft_pkg::ICLR_READ}; // R19
		end else if (req.addr == mft_pkg::OFS_CNT1) begin
			reg_rdata <= first_counter_value_r;
		end else if (req.addr == mft_pkg::OFS_CNT2) begin
			reg_rdata <= second_counter_value_r;
		end else if (req.addr == mft_pkg::OFS_RCA) begin
			reg_rdata <= reload_capture_first_r;
		end else if (req.addr == mft_pkg::OFS_RCB) begin
			reg_rdata <= reload_capture_second_r;
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_iclr_rd;
		reg_rd && reg_addr == mft_pkg::OFS_ICLR;
	endsequence

	sequence s_pre_run;
		ctl_r.global_timer_enable && $stable(prescale_value_r) && !$past(wr_prsc);
	endsequence

	clear_reads_ones_a: assert property (s_iclr_rd |=> reg_rdata == 16'h00FF) // R19
		else $error("clear register did not read all ones");
	div_period_a: assert property (s_pre_run ##0 pre_tick ##1 s_pre_run
		|-> pre_cnt_r == 5'h00) // R1
		else $error("prescaler did not restart after tick");
	tick_gap_a: assert property (pre_tick && prescale_value_r == 5'h03
		&& ctl_r.global_timer_enable ##1 ctl_r.global_timer_enable && $stable(prescale_value_r)
		|-> (!pre_tick || $past(wr_prsc) || $past(wr_prsc, 2)) [*3]) // R1
		else $error("prescaled tick too frequent");
	stop_no_tick_a: assert property (first_clock_select_r == mft_pkg::CS_STOP
		|| first_clock_select_r > mft_pkg::CS_SLOW |-> !tick1) // R3 R24
		else $error("stopped counter ticked");
	disable_clears_a: assert property (!ctl_r.global_timer_enable |=> pending_r == 4'h0
		&& pre_cnt_r == 5'h00 && !timer_io_pin_a_oe) // R14
		else $error("disable did not clear state");
	zero_write_keeps_a: assert property (pending_r[0] && !wr_iclr && ctl_r.global_timer_enable
		##1 ctl_r.global_timer_enable |-> pending_r[0]) // R16
		else $error("pending flag lost without clear");
	clear_works_a: assert property (wr_iclr && req.wdata[3] && !hw_set[3]
		&& !(wr_ictl) |=> !pending_r[3]) // R18
		else $error("pending D not cleared");
	irq_gate_a: assert property (timer_irq2 |-> $past(irq_en_r[3])
		&& $past(pending_r[3])) // R17 R21
		else $error("request 2 without enable");
	sw_wins_a: assert property (wr_ctrl && pwm_on && uf1
		|=> ctl_r.pin_a_output_state == $past(req.wdata[6])) // R12
		else $error("hardware toggle beat software write");
	pwm_toggle_a: assert property (pwm_on && uf1 && !wr_ctrl
		|=> ctl_r.pin_a_output_state != $past(ctl_r.pin_a_output_state)) // R23
		else $error("pin A did not toggle on underflow");
	cnt_write_block_a: assert property (!ctl_r.global_timer_enable && reg_wr
		&& reg_addr == mft_pkg::OFS_CNT1 |=> $stable(first_counter_value_r)) // R13
		else $error("counter written while disabled");
endmodule

// file: bench/mft_pin_model.sv
// Pad-side model of pin A, pin B and the slow clock source.
`timescale 1ns/1ps
module mft_pin_model (
	input wire logic a_oe, // Timer drives pin A when high.
	input wire logic a_out, // Timer drive level for pin A.
	input wire logic a_ext, // Level the outside world offers on pin A.
	input wire logic b_ext, // Level the outside world puts on pin B.
	input wire logic slow_ext, // Slow clock, held still between bursts.
	output logic pin_a, // Resolved level of pin A.
	output logic pin_b, // Level seen on pin B.
	output logic slow_clk // Slow clock seen by the timer.
);
	// The outside driver backs off whenever the timer drives pin A.
	assign pin_a = a_oe ? a_out : a_ext;
	assign pin_b = b_ext;
	assign slow_clk = slow_ext;
endmodule

// file: bench/tb_mft_timer.sv
// Self-checking testbench of the multi-function timer.
`timescale 1ns/1ps
module tb_mft_timer;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic a_ext = 1'b0;
	logic b_ext = 1'b0;
	logic slow_ext = 1'b0;
	logic pin_a, pin_b, slow_clk, a_oe, a_out, irq1, irq2;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int p;
	logic [15:0] v0, v1, d;
	logic [7:0] regs [4] = '{mft_pkg::OFS_CNT1, mft_pkg::OFS_RCA,
		mft_pkg::OFS_RCB, mft_pkg::OFS_CNT2};
	logic [2:0] idle_codes [4] = '{3'h0, 3'h5, 3'h6, 3'h7};

	always #5 mclk = ~mclk;

	mft_timer mft_timer_inst (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_io_pin_a_in(pin_a), .timer_io_pin_a_out(a_out),
		.timer_io_pin_a_oe(a_oe), .timer_io_pin_b_in(pin_b),
		.slow_clk_in(slow_clk), .timer_irq1(irq1), .timer_irq2(irq2)
	);

	mft_pin_model mft_pin_model_inst (
		.a_oe(a_oe), .a_out(a_out), .a_ext(a_ext), .b_ext(b_ext),
		.slow_ext(slow_ext), .pin_a(pin_a), .pin_b(pin_b),
		.slow_clk(slow_clk)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus cycles; each leaves one idle edge so strobes never re-assert at once.
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
		@(posedge mclk);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected interrupt control byte after a write to it or to the clear port.
	function automatic logic [7:0] ictl_after(input logic [7:0] old,
		input logic [7:0] wv, input logic to_clear);
		if (to_clear) begin
			return {old[7:4], old[3:0] & ~wv[3:0]};
		end
		return {wv[7:4], old[3:0] | wv[3:0]};
	endfunction

	task automatic complete_run;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("BAD %0t run did not finish", $time);
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hF4C6AD21));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(mft_pkg::OFS_PRSC, d); chk(d, 16'h0000);
		rd(mft_pkg::OFS_CKC, d); chk(d, 16'h0000);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h0000);
		rd(mft_pkg::OFS_ICLR, d); chk(d, 16'h00FF);
		rd(8'h52, d); chk(d, 16'h0000);
		wr(mft_pkg::OFS_PRSC, 16'hFFFF);
		rd(mft_pkg::OFS_PRSC, d); chk(d, 16'h001F);
		wr(mft_pkg::OFS_CKC, 16'hFFFF);
		rd(mft_pkg::OFS_CKC, d); chk(d, 16'h003F);
		wr(mft_pkg::OFS_CKC, 16'h0000);
		// Word registers keep their value while the timer is disabled.
		foreach (regs[i]) begin
			v0 = 16'($urandom);
			wr(mft_pkg::OFS_CTRL, 16'h0080);
			wr(regs[i], v0);
			rd(regs[i], d); chk(d, v0);
			wr(mft_pkg::OFS_CTRL, 16'h0000);
			wr(regs[i], ~v0);
			rd(regs[i], d); chk(d, v0);
		end
		wr(mft_pkg::OFS_CTRL, 16'h0080);
		wr(mft_pkg::OFS_ICTL, 16'h000F);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h000F);
		wr(mft_pkg::OFS_ICTL, 16'h0000);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h000F);
		wr(mft_pkg::OFS_ICLR, 16'h0005);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h000A);
		wr(mft_pkg::OFS_ICLR, 16'h0000);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h000A);
		chk({irq1, irq2}, 16'h0000);
		wr(mft_pkg::OFS_ICTL, 16'h0080);
		idle(2);
		chk({irq1, irq2}, 16'h0001);
		wr(mft_pkg::OFS_ICTL, 16'h0020);
		idle(2);
		chk({irq1, irq2}, 16'h0002);
		wr(mft_pkg::OFS_CTRL, 16'h0000);
		idle(2);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h0020);
		wr(mft_pkg::OFS_ICTL, 16'h002F);
		rd(mft_pkg::OFS_ICTL, d); chk(d, 16'h0020);
		wr(mft_pkg::OFS_ICTL, 16'h0000);
		// Random enable writes and pending clears against the expected byte.
		wr(mft_pkg::OFS_CTRL, 16'h0080);
		d = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			v0 = 16'($urandom);
			wr(i[0] ? mft_pkg::OFS_ICLR : mft_pkg::OFS_ICTL, v0);
			d = {8'h00, ictl_after(d[7:0], v0[7:0], i[0])};
			rd(mft_pkg::OFS_ICTL, v1); chk(v1, d);
		end
		wr(mft_pkg::OFS_ICTL, 16'h0000);
		// Two reads spaced by a whole number of prescaled periods.
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
			wr(mft_pkg::OFS_PRSC, 16'(p));
			wr(regs[3 * (i % 2)], 16'h8000);
			wr(mft_pkg::OFS_CKC, (i % 2) ? 16'h0008 : 16'h0001);
			rd(regs[3 * (i % 2)], v0);
			idle(4 * (p + 1) - 2);
			rd(regs[3 * (i % 2)], v1); chk(v0 - v1, 16'h0004);
		end
		wr(mft_pkg::OFS_PRSC, 16'h0000);
		foreach (idle_codes[i]) begin
			wr(mft_pkg::OFS_CKC, {13'h0000, idle_codes[i]});
			rd(mft_pkg::OFS_CNT1, v0);
			idle(6);
			rd(mft_pkg::OFS_CNT1, v1); chk(v0 - v1, 16'h0000);
		end
		wr(mft_pkg::OFS_CKC, 16'h0002);
		for (int e = 0; e < 2; e++) begin
			wr(mft_pkg::OFS_CTRL, 16'h0080 | 16'(e << 3));
			idle(8);
			rd(mft_pkg::OFS_CNT1, v0);
			b_ext <= 1'b1;
			idle(8);
			rd(mft_pkg::OFS_CNT1, v1); chk(v0 - v1, 16'(e));
			b_ext <= 1'b0;
			idle(8);
			rd(mft_pkg::OFS_CNT1, d); chk(v1 - d, 16'(1 - e));
		end
		wr(mft_pkg::OFS_CKC, 16'h0003);
		for (int e = 0; e < 2; e++) begin
			wr(mft_pkg::OFS_CTRL, 16'h0082 | 16'(e << 3));
			b_ext <= ~e[0];
			idle(6);
			rd(mft_pkg::OFS_CNT1, v0);
			idle(8);
			rd(mft_pkg::OFS_CNT1, v1); chk(v0 - v1, 16'h0000);
			b_ext <= e[0];
			idle(6);
			rd(mft_pkg::OFS_CNT1, v0);
			idle(8);
			rd(mft_pkg::OFS_CNT1, v1); chk(16'(v0 != v1), 16'h0001);
		end
		b_ext <= 1'b0;
		wr(mft_pkg::OFS_CKC, 16'h0004);
		rd(mft_pkg::OFS_CNT1, v0);
		repeat (3) begin
			slow_ext <= 1'b1;
			idle(8);
			slow_ext <= 1'b0;
			idle(8);
		end
		rd(mft_pkg::OFS_CNT1, v1); chk(v0 - v1, 16'h0003);
		// Capture and preset; counter 1 is stopped so its values are exact, counter 2 runs prescaled for the mode 4 check.
		wr(mft_pkg::OFS_CKC, 16'h0000);
		wr(mft_pkg::OFS_ICLR, 16'h000F);
		wr(mft_pkg::OFS_CTRL, 16'h0095);
		wr(mft_pkg::OFS_CNT1, 16'h1234);
		a_ext <= 1'b1;
		idle(8);
		rd(mft_pkg::OFS_CNT1, d); chk(d, 16'hFFFF);
		rd(mft_pkg::OFS_RCA, d); chk(d, 16'h1234);
		rd(mft_pkg::OFS_ICTL, d); chk(d & 16'h0001, 16'h0001);
		wr(mft_pkg::OFS_CTRL, 16'h0081);
		wr(mft_pkg::OFS_CNT1, 16'h4321);
		a_ext <= 1'b0;
		idle(8);
		rd(mft_pkg::OFS_RCA, d); chk(d, 16'h4321);
		rd(mft_pkg::OFS_CNT1, d); chk(d, 16'h4321);
		wr(mft_pkg::OFS_CTRL, 16'h00A9);
		wr(mft_pkg::OFS_CNT1, 16'h5555);
		b_ext <= 1'b1;
		idle(8);
		rd(mft_pkg::OFS_CNT1, d); chk(d, 16'hFFFF);
		rd(mft_pkg::OFS_RCB, d); chk(d, 16'h5555);
		b_ext <= 1'b0;
		wr(mft_pkg::OFS_PRSC, 16'h001F);
		wr(mft_pkg::OFS_CKC, 16'h0008);
		wr(mft_pkg::OFS_CTRL, 16'h00AB);
		wr(mft_pkg::OFS_CNT2, 16'h0100);
		b_ext <= 1'b1;
		idle(8);
		rd(mft_pkg::OFS_CNT2, d); chk(16'(d > 16'hFFF0), 16'h0001);
		// PWM on pin A: reload 3 gives a toggle every fourth cycle.
		wr(mft_pkg::OFS_CKC, 16'h0000);
		wr(mft_pkg::OFS_PRSC, 16'h0000);
		wr(mft_pkg::OFS_ICLR, 16'h000F);
		wr(mft_pkg::OFS_CTRL, 16'h00D0);
		wr(mft_pkg::OFS_RCA, 16'h0003);
		wr(mft_pkg::OFS_CNT1, 16'h0003);
		wr(mft_pkg::OFS_CKC, 16'h0001);
		idle(4);
		@(negedge mclk);
		chk({15'h0000, a_oe}, 16'h0001);
		v0 = {15'h0000, a_out};
		repeat (4) @(negedge mclk);
		chk({15'h0000, a_out}, {15'h0000, ~v0[0]});
		@(posedge mclk);
		rd(mft_pkg::OFS_ICTL, d); chk(d & 16'h0001, 16'h0001);
		chk({irq1, irq2}, 16'h0000);
		wr(mft_pkg::OFS_ICTL, 16'h0010);
		idle(2);
		chk({irq1, irq2}, 16'h0002);
		wr(mft_pkg::OFS_CTRL, 16'h0000);
		idle(2);
		chk({a_oe, irq1}, 16'h0000);
		complete_run();
	end
endmodule
